// File: hpfu_pkg.sv
// Shared constants and types for the host pixel unpacker
package hpfu_pkg;
   // Link select pin codes
   localparam logic [3:0] LINK_P8_I = 4'h0;
   localparam logic [3:0] LINK_P16_I = 4'h1;
   localparam logic [3:0] LINK_P9_I = 4'h2;
   localparam logic [3:0] LINK_S3_I = 4'h5;
   localparam logic [3:0] LINK_S4_I = 4'h6;
   localparam logic [3:0] LINK_P8_II = 4'h9;
   localparam logic [3:0] LINK_P9_II = 4'hB;
   localparam logic [3:0] LINK_S3_II = 4'hD;
   localparam logic [3:0] LINK_S4_II = 4'hE;
   // Pixel format codes
   localparam logic [2:0] FMT_16BPP = 3'h5;
   localparam logic [2:0] FMT_18BPP = 3'h6;
   // Display sync mode codes
   localparam logic [1:0] DSM_INTERNAL = 2'h0;
   localparam logic [1:0] DSM_VSYNC = 2'h2;
   // Frame memory geometry and buffering
   localparam int unsigned FM_COLS = 240;
   localparam int unsigned FM_ROWS = 320;
   localparam int unsigned PIX_W = 18;
   localparam int unsigned LINK_W = 18;
   localparam int unsigned FIFO_DEPTH = 4;
   // Lane group base bits for the upper-lane links
   localparam int unsigned LANE8_HI_LSB = 10;
   localparam int unsigned LANE9_HI_LSB = 9;
   // Reset values
   localparam logic [7:0] CMD_RESET = 8'h00;
   localparam logic [1:0] PHASE_RESET = 2'h0;

   // One stored pixel, six bits per colour
   typedef struct packed {
      logic [5:0] red;
      logic [5:0] green;
      logic [5:0] blue;
   } hpfu_pixel_t;

   // One captured host transfer
   typedef struct packed {
      logic is_data;
      logic [17:0] word;
   } hpfu_xfer_t;

   // Lane group width in use
   typedef enum logic [3:0] {
      LANE_NONE = 4'b0001,
      LANE_8 = 4'b0010,
      LANE_9 = 4'b0100,
      LANE_16 = 4'b1000
   } hpfu_lane_t;

   // Display scanner states
   typedef enum logic [1:0] {
      SCAN_IDLE = 2'b01,
      SCAN_RUN = 2'b10
   } hpfu_scan_t;
endpackage : hpfu_pkg

// File: hpfu_unpacker.sv
`timescale 1ns/100ps

// Small synchronous FIFO in front of the frame memory write port
module hpfu_fifo #(
   parameter int unsigned WIDTH = 18,
   parameter int unsigned DEPTH = 4
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] store [DEPTH];  // Entry storage
   logic [AW-1:0] wr_ptr;  // Next entry to fill
   logic [AW-1:0] rd_ptr;  // Oldest entry
   logic [AW:0] count;  // Entries held
   logic [AW-1:0] next_wr_ptr;
   logic [AW-1:0] next_rd_ptr;
   logic [AW:0] next_count;
   logic push;
   logic pop;

   // Handshake flags and pointer arithmetic
   always_comb begin
      in_ready = (count != (AW+1)'(DEPTH));
      out_valid = (count != '0);
      out_data = store[rd_ptr];
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      if (push) begin
         next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      next_count = count + (AW+1)'(push) - (AW+1)'(pop);
   end

   // Pointer registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   // Entry storage, no reset needed
   always_ff @(posedge clk) begin
      if (push) begin
         store[wr_ptr] <= in_data;
      end
   end
endmodule : hpfu_fifo

module hpfu_unpacker
   import hpfu_pkg::*;
#(
   parameter int unsigned COLS = FM_COLS,
   parameter int unsigned ROWS = FM_ROWS
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [3:0] host_link_select_pins,
   input wire logic host_write_n,
   input wire logic data_command_select,
   input wire logic [LINK_W-1:0] host_data,
   input wire logic vsync_n,
   input wire logic [1:0] display_sync_mode,
   input wire logic memory_path_select,
   input wire logic [2:0] host_pixel_format,
   input wire logic [1:0] video_port_variant,
   input wire logic partial_request,
   input wire logic scroll_request,
   input wire logic interlace_request,
   input wire logic fm_write_hold,
   output hpfu_pixel_t scan_pixel,
   output logic scan_pixel_valid,
   output logic frame_start,
   output logic vsync_mode_active,
   output logic partial_active,
   output logic scroll_active,
   output logic interlace_active,
   output logic rgb_port_active,
   output logic cmd_valid,
   output logic [7:0] cmd_byte,
   output logic link_busy,
   output logic pixel_dropped,
   output logic vsync_overrun
);
   localparam int unsigned FM_SIZE = COLS * ROWS;
   localparam int unsigned FA_W = $clog2(FM_SIZE);
   localparam logic [FA_W-1:0] FM_LAST = FA_W'(FM_SIZE - 1);

   // Pin synchronisers: two stages, with a third stage on the write strobe and vsync for edge detection
   logic [3:0] im_s1, im_s2;
   logic wr_s1, wr_s2, wr_s3;
   logic dc_s1, dc_s2;
   logic [LINK_W-1:0] d_s1, d_s2;
   logic vs_s1, vs_s2, vs_s3;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         {im_s1, im_s2} <= '0;
         {wr_s1, wr_s2, wr_s3} <= 3'h7;
         {dc_s1, dc_s2} <= '0;
         {d_s1, d_s2} <= '0;
         {vs_s1, vs_s2, vs_s3} <= 3'h7;
      end else begin
         {im_s1, im_s2} <= {host_link_select_pins, im_s1};
         {wr_s1, wr_s2, wr_s3} <= {host_write_n, wr_s1, wr_s2};
         {dc_s1, dc_s2} <= {data_command_select, dc_s1};
         {d_s1, d_s2} <= {host_data, d_s1};
         {vs_s1, vs_s2, vs_s3} <= {vsync_n, vs_s1, vs_s2};
      end
   end

   // Transfer capture on the write strobe's rising edge
   hpfu_xfer_t xfer;
   logic take;
   logic vs_fall;
   always_comb begin
      take = wr_s2 && !wr_s3;
      vs_fall = !vs_s2 && vs_s3;
      xfer.is_data = dc_s2;
      xfer.word = d_s2;
   end

   // Lane group decode from the select pins
   hpfu_lane_t lane_kind;
   logic lane_hi;
   logic [7:0] lane8;
   logic [8:0] lane9;
   always_comb begin
      lane_hi = 1'b0;
      lane_kind = LANE_NONE;
      if (im_s2 == LINK_P8_I || im_s2 == LINK_S3_I || im_s2 == LINK_S4_I) begin
         lane_kind = LANE_8;
      end else if (im_s2 == LINK_S3_II || im_s2 == LINK_S4_II) begin
         lane_kind = LANE_8;
      end else if (im_s2 == LINK_P8_II) begin
         lane_kind = LANE_8;
         lane_hi = 1'b1;
      end else if (im_s2 == LINK_P9_I) begin
         lane_kind = LANE_9;
      end else if (im_s2 == LINK_P9_II) begin
         lane_kind = LANE_9;
         lane_hi = 1'b1;
      end else if (im_s2 == LINK_P16_I) begin
         lane_kind = LANE_16;
      end
      lane8 = lane_hi ? xfer.word[LANE8_HI_LSB +: 8] : xfer.word[7:0];
      lane9 = lane_hi ? xfer.word[LANE9_HI_LSB +: 9] : xfer.word[8:0];
   end

   // Pixel assembly across transfers
   logic [1:0] phase, next_phase;  // Transfers held for this pixel
   logic [11:0] acc, next_acc;  // Earlier transfers of this pixel
   logic [7:0] prev_lane8, next_prev_lane8;  // Lane byte of the latest transfer
   logic next_cmd_valid;
   logic [7:0] next_cmd_byte;
   logic push;
   logic reject;
   hpfu_pixel_t push_pix;
   logic fifo_in_ready;
   always_comb begin
      next_phase = phase;
      next_acc = acc;
      next_prev_lane8 = take ? lane8 : prev_lane8;
      next_cmd_valid = 1'b0;
      next_cmd_byte = cmd_byte;
      push = 1'b0;
      reject = 1'b0;
      push_pix = '0;
      if (take && !xfer.is_data) begin
         // Command restarts pixel assembly
         next_cmd_valid = 1'b1;
         next_cmd_byte = (lane_kind == LANE_16) ? xfer.word[7:0] : lane8;
         next_phase = PHASE_RESET;
      end else if (take) begin
         if (lane_kind == LANE_16 && host_pixel_format == FMT_16BPP) begin
            // One transfer carries a whole 565 pixel
            push = 1'b1;
            push_pix = '{{xfer.word[15:11], xfer.word[15]}, xfer.word[10:5],
                         {xfer.word[4:0], xfer.word[4]}};
         end else if (lane_kind == LANE_8 && host_pixel_format == FMT_16BPP) begin
            // Red and green high first, then green low and blue
            if (phase == 2'h0) begin
               next_acc[7:0] = lane8;
               next_phase = 2'h1;
            end else begin
               push = 1'b1;
               push_pix = '{{acc[7:3], acc[7]}, {acc[2:0], lane8[7:5]},
                            {lane8[4:0], lane8[4]}};
               next_phase = PHASE_RESET;
            end
         end else if (lane_kind == LANE_8 && host_pixel_format == FMT_18BPP) begin
            // Red, green, blue on the upper six lanes
            if (phase == 2'h0) begin
               next_acc[5:0] = lane8[7:2];
               next_phase = 2'h1;
            end else if (phase == 2'h1) begin
               next_acc[11:6] = lane8[7:2];
               next_phase = 2'h2;
            end else begin
               push = 1'b1;
               push_pix = '{acc[5:0], acc[11:6], lane8[7:2]};
               next_phase = PHASE_RESET;
            end
         end else if (lane_kind == LANE_9 && host_pixel_format == FMT_18BPP) begin
            // Red and green high, then green low and blue
            if (phase == 2'h0) begin
               next_acc[8:0] = lane9;
               next_phase = 2'h1;
            end else begin
               push = 1'b1;
               push_pix = '{acc[8:3], {acc[2:0], lane9[8:6]}, lane9[5:0]};
               next_phase = PHASE_RESET;
            end
         end else begin
            // Unsupported pairing, such as 9-bit 565, is discarded
            reject = 1'b1;
            next_phase = PHASE_RESET;
         end
      end
   end

   // Assembly registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         phase <= PHASE_RESET;
         acc <= '0;
         prev_lane8 <= '0;
         cmd_valid <= 1'b0;
         cmd_byte <= CMD_RESET;
         pixel_dropped <= 1'b0;
         link_busy <= 1'b0;
      end else begin
         phase <= next_phase;
         acc <= next_acc;
         prev_lane8 <= next_prev_lane8;
         cmd_valid <= next_cmd_valid;
         cmd_byte <= next_cmd_byte;
         pixel_dropped <= reject || (push && !fifo_in_ready);
         link_busy <= !fifo_in_ready;
      end
   end

   // Write buffer between link and frame memory
   logic fifo_out_valid;
   hpfu_pixel_t fifo_out;
   hpfu_fifo #(
      .WIDTH(PIX_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rstn(rstn),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(push_pix),
      .out_valid(fifo_out_valid),
      .out_ready(!fm_write_hold),
      .out_data(fifo_out)
   );

   // Frame memory with separate write and scan read ports
   hpfu_pixel_t fm [FM_SIZE];
   logic [FA_W-1:0] wr_addr, next_wr_addr;
   logic fm_write;
   always_comb begin
      fm_write = fifo_out_valid && !fm_write_hold;
      next_wr_addr = wr_addr;
      if (fm_write) begin
         next_wr_addr = (wr_addr == FM_LAST) ? '0 : wr_addr + 1'b1;
      end
   end

   // Scanner state and mode latch
   hpfu_scan_t scan_state, next_scan_state;
   logic [FA_W-1:0] scan_addr, next_scan_addr;
   logic next_vsync_mode;
   logic pending_vsync;
   logic frame_begin;
   always_comb begin
      pending_vsync = (display_sync_mode == DSM_VSYNC) && !memory_path_select;
      next_scan_state = scan_state;
      next_scan_addr = scan_addr;
      next_vsync_mode = vsync_mode_active;
      frame_begin = 1'b0;
      case (scan_state)
         SCAN_IDLE: begin
            if (vs_fall || (!vsync_mode_active && !pending_vsync)) begin
               next_vsync_mode = pending_vsync;
               next_scan_state = SCAN_RUN;
               next_scan_addr = '0;
               frame_begin = 1'b1;
            end
         end
         SCAN_RUN: begin
            if (scan_addr != FM_LAST) begin
               next_scan_addr = scan_addr + 1'b1;
            end else if (vsync_mode_active || pending_vsync) begin
               next_scan_state = SCAN_IDLE;
            end else begin
               next_scan_addr = '0;
               frame_begin = 1'b1;
            end
         end
         default: begin
            next_scan_state = SCAN_IDLE;
         end
      endcase
   end

   // Scanner, mode and status registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         scan_state <= SCAN_IDLE;
         scan_addr <= '0;
         wr_addr <= '0;
         vsync_mode_active <= 1'b0;
         frame_start <= 1'b0;
         scan_pixel_valid <= 1'b0;
         partial_active <= 1'b0;
         scroll_active <= 1'b0;
         interlace_active <= 1'b0;
         rgb_port_active <= 1'b0;
         vsync_overrun <= 1'b0;
      end else begin
         scan_state <= next_scan_state;
         scan_addr <= next_scan_addr;
         wr_addr <= next_wr_addr;
         vsync_mode_active <= next_vsync_mode;
         frame_start <= frame_begin;
         scan_pixel_valid <= (scan_state == SCAN_RUN);
         partial_active <= partial_request && !next_vsync_mode;
         scroll_active <= scroll_request && !next_vsync_mode;
         interlace_active <= interlace_request && !next_vsync_mode;
         rgb_port_active <= video_port_variant[1];
         vsync_overrun <= vs_fall && (scan_state == SCAN_RUN) && vsync_mode_active;
      end
   end

   // Memory ports: a same-cycle read sees the old word, never a torn one
   always_ff @(posedge clk) begin
      if (fm_write) begin
         fm[wr_addr] <= fifo_out;
      end
      scan_pixel <= fm[scan_addr];
   end

   chk_mode_entry: assert property (@(posedge clk) disable iff (!rstn)
      frame_start && vsync_mode_active
      |-> $past(display_sync_mode) == DSM_VSYNC && !$past(memory_path_select))
      else $error("sync mode entered without its settings");
   chk_mode_hold: assert property (@(posedge clk) disable iff (!rstn)
      !frame_start |-> $stable(vsync_mode_active))
      else $error("display mode changed inside a frame");
   chk_frame_pulse: assert property (@(posedge clk) disable iff (!rstn)
      frame_start && vsync_mode_active |-> $past(vs_fall))
      else $error("sync frame began without a frame pulse");
   chk_no_partial: assert property (@(posedge clk) disable iff (!rstn)
      vsync_mode_active |-> !partial_active && !scroll_active && !interlace_active)
      else $error("partial, scroll or interlace active in sync mode");
   chk_pixel_565: assert property (@(posedge clk) disable iff (!rstn)
      push && lane_kind == LANE_8 && host_pixel_format == FMT_16BPP
      |-> push_pix.blue[5:1] == lane8[4:0] && push_pix.red[5:1] == prev_lane8[7:3])
      else $error("8-bit 565 pixel misassembled");
   chk_pixel_666: assert property (@(posedge clk) disable iff (!rstn)
      push && lane_kind == LANE_8 && host_pixel_format == FMT_18BPP
      |-> push_pix.blue == lane8[7:2])
      else $error("8-bit 666 pixel misassembled");
   chk_pixel_9bit: assert property (@(posedge clk) disable iff (!rstn)
      push && lane_kind == LANE_9
      |-> push_pix.blue == lane9[5:0] && push_pix.green[2:0] == lane9[8:6])
      else $error("9-bit pixel misassembled");
   chk_cmd_byte: assert property (@(posedge clk) disable iff (!rstn)
      take && !xfer.is_data && lane_kind == LANE_8 |=> cmd_valid && cmd_byte == $past(lane8))
      else $error("command byte not taken from lane group");
   chk_mem_wrap: assert property (@(posedge clk) disable iff (!rstn)
      fm_write && wr_addr == FM_LAST |=> wr_addr == '0)
      else $error("frame memory pointer failed to wrap");
endmodule : hpfu_unpacker

// File: hpfu_host_model.sv
`timescale 1ns/100ps

// Host bus master: one write strobe per request, then the bus is released
module hpfu_host_model
   import hpfu_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic req,
   input wire hpfu_xfer_t req_xfer,
   output logic req_done,
   output logic host_write_n,
   output logic data_command_select,
   output logic [LINK_W-1:0] host_data
);
   logic [2:0] step; // Cycle within the current transfer

   // Strobe low two cycles, data held three more after it rises
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         step <= 3'h0;
         req_done <= 1'b0;
         host_write_n <= 1'b1;
         data_command_select <= 1'b1;
         host_data <= 18'h00000;
      end else begin
         req_done <= 1'b0;
         if (step == 3'h0) begin
            // Start at full speed when asked, except in the cycle that req_done is high
            if (req && !req_done) begin
               host_write_n <= 1'b0;
               data_command_select <= req_xfer.is_data;
               host_data <= req_xfer.word;
               step <= 3'h1;
            end
         end else if (step == 3'h5) begin
            // Released bus shows the inverse of the last word
            host_data <= ~host_data;
            data_command_select <= ~data_command_select;
            req_done <= 1'b1;
            step <= 3'h0;
         end else begin
            // Strobe rises after two low cycles
            if (step == 3'h2) host_write_n <= 1'b1;
            step <= step + 3'h1;
         end
      end
   end
endmodule : hpfu_host_model

// File: testbench.sv
`timescale 1ns/100ps

// Self-checking bench for the pixel unpacker on a 4x2 memory
module testbench
   import hpfu_pkg::*;
();
   localparam int NPIX = 8; // Pixels in the reduced frame
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] host_link_select_pins = LINK_P8_I;
   logic vsync_n = 1'b1;
   logic [1:0] display_sync_mode = DSM_INTERNAL;
   logic memory_path_select = 1'b0;
   logic [2:0] host_pixel_format = FMT_16BPP;
   logic [1:0] video_port_variant = 2'h0;
   logic partial_request = 1'b0;
   logic scroll_request = 1'b0;
   logic interlace_request = 1'b0;
   logic fm_write_hold = 1'b0;
   logic req = 1'b0;
   hpfu_xfer_t req_xfer = 19'h00000;
   logic req_done, host_write_n, data_command_select;
   logic [LINK_W-1:0] host_data;
   hpfu_pixel_t scan_pixel;
   logic scan_pixel_valid, frame_start, vsync_mode_active, partial_active;
   logic scroll_active, interlace_active, rgb_port_active, cmd_valid;
   logic link_busy, pixel_dropped, vsync_overrun;
   logic [7:0] cmd_byte;
   int fail_count = 0;
   int checks_done = 0;
   int cmd_seen = 0, drop_seen = 0, ovr_seen = 0, frames = 0, pos = 0;
   int exp_cmd = 0, exp_drop = 0, wptr = 0;
   hpfu_pixel_t shown [NPIX]; // Last scanned frame
   hpfu_pixel_t exp_mem [NPIX]; // Expected memory contents
   bit written [NPIX];
   logic [3:0] links [9] = '{LINK_P8_I, LINK_P8_II, LINK_P9_I, LINK_P9_II, LINK_P16_I,
      LINK_S3_I, LINK_S3_II, LINK_S4_I, LINK_S4_II};

   hpfu_unpacker #(.COLS(4), .ROWS(2)) u_dut (.clk, .rstn, .host_link_select_pins,
      .host_write_n, .data_command_select, .host_data, .vsync_n, .display_sync_mode,
      .memory_path_select, .host_pixel_format, .video_port_variant, .partial_request,
      .scroll_request, .interlace_request, .fm_write_hold, .scan_pixel, .scan_pixel_valid,
      .frame_start, .vsync_mode_active, .partial_active, .scroll_active, .interlace_active,
      .rgb_port_active, .cmd_valid, .cmd_byte, .link_busy, .pixel_dropped, .vsync_overrun);
   hpfu_host_model u_host (.clk, .rstn, .req, .req_xfer, .req_done, .host_write_n,
      .data_command_select, .host_data);

   always #50 clk = ~clk;

   // Count pulses and capture each scanned frame
   always @(posedge clk) begin
      if (cmd_valid === 1'b1) cmd_seen <= cmd_seen + 1;
      if (pixel_dropped === 1'b1) drop_seen <= drop_seen + 1;
      if (vsync_overrun === 1'b1) ovr_seen <= ovr_seen + 1;
      // Read data trails the scan address, so the last pixel lands with the next start
      if (scan_pixel_valid === 1'b1 && pos < NPIX) begin
         shown[pos] <= scan_pixel;
         pos <= pos + 1;
      end
      if (frame_start === 1'b1) begin
         frames <= frames + 1;
         pos <= 0;
      end
   end

   task automatic chk_vec(input logic [17:0] got, input logic [17:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk_vec

   task automatic chk_cnt(input int got, input int exp, input string what);
      checks_done++;
      if (got != exp) begin
         fail_count++;
         $display("MISMATCH %0t %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask : chk_cnt

   task automatic give_verdict();
      if (fail_count == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : give_verdict

   task automatic ticks(input int n);
      repeat (n) @(posedge clk);
   endtask : ticks

   // One bus transfer through the host model
   task automatic xfer(input logic is_data, input logic [17:0] w);
      int n;
      @(posedge clk);
      req <= 1'b1;
      req_xfer <= {is_data, w};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (req_done !== 1'b1 && n < 50);
      req <= 1'b0;
      chk_vec(req_done, 1'b1, "transfer done");
   endtask : xfer

   task automatic setlink(input logic [3:0] code);
      @(posedge clk);
      host_link_select_pins <= code;
      ticks(6);
   endtask : setlink

   // Place a byte or word on the lane group, unused lanes high
   function automatic logic [17:0] lane(input logic [8:0] v);
      case (host_link_select_pins)
         LINK_P8_II: return {v[7:0], 10'h3FF};
         LINK_P9_II: return {v, 9'h1FF};
         LINK_P9_I: return {9'h1FF, v};
         default: return {10'h3FF, v[7:0]};
      endcase
   endfunction : lane

   task automatic put_pix(input hpfu_pixel_t p);
      exp_mem[wptr] = p;
      written[wptr] = 1'b1;
      wptr = (wptr + 1) % NPIX;
   endtask : put_pix

   task automatic send_cmd(input logic [7:0] c);
      // The 9-bit type II link carries commands on its top eight lanes
      xfer(1'b0, lane(host_link_select_pins == LINK_P9_II ? {c, 1'b1} : {1'b1, c}));
      exp_cmd++;
      ticks(4);
      chk_cnt(cmd_seen, exp_cmd, "command pulses");
      chk_vec(cmd_byte, c, "command byte");
   endtask : send_cmd

   task automatic send565(input logic [4:0] r, input logic [5:0] g, input logic [4:0] b,
      input bit ok);
      host_pixel_format <= FMT_16BPP;
      if (!ok) begin
         xfer(1'b1, lane({1'b1, r, g[5:3]}));
         exp_drop++;
      end else if (host_link_select_pins == LINK_P16_I) begin
         xfer(1'b1, {2'h3, r, g, b});
      end else begin
         xfer(1'b1, lane({1'b1, r, g[5:3]}));
         xfer(1'b1, lane({1'b1, g[2:0], b}));
      end
      if (ok) put_pix({r, r[4], g, b, b[4]});
   endtask : send565

   task automatic send666(input hpfu_pixel_t p, input bit ok);
      bit nine;
      nine = host_link_select_pins == LINK_P9_I || host_link_select_pins == LINK_P9_II;
      host_pixel_format <= FMT_18BPP;
      if (!ok) begin
         xfer(1'b1, {2'h3, p.red, p.green, p.blue[5:2]});
         exp_drop++;
      end else if (nine) begin
         xfer(1'b1, lane({p.red, p.green[5:3]}));
         xfer(1'b1, lane({p.green[2:0], p.blue}));
      end else begin
         xfer(1'b1, lane({1'b1, p.red, 2'h3}));
         xfer(1'b1, lane({1'b1, p.green, 2'h3}));
         xfer(1'b1, lane({1'b1, p.blue, 2'h3}));
      end
      if (ok) put_pix(p);
   endtask : send666

   task automatic cmp_mem();
      for (int i = 0; i < NPIX; i++) begin
         if (written[i]) chk_vec(shown[i], exp_mem[i], "frame memory");
      end
   endtask : cmp_mem

   task automatic check_frame();
      int f0;
      f0 = frames;
      for (int n = 0; n < 200 && frames < f0 + 2; n++) @(posedge clk);
      chk_cnt(frames - f0, 2, "frames seen");
      cmp_mem();
   endtask : check_frame

   // Frame pulse two cycles low, then a gap of the given number of cycles
   task automatic vpulse(input int gap);
      @(posedge clk);
      vsync_n <= 1'b0;
      ticks(2);
      vsync_n <= 1'b1;
      ticks(gap);
   endtask : vpulse

   // Main sequence
   initial begin
      int f0;
      ticks(20);
      rstn <= 1'b1;
      ticks(4);
      // Every link code: command, 16-bit pixel, 18-bit pixel
      foreach (links[i]) begin
         setlink(links[i]);
         send_cmd(8'hA0 + 8'(i));
         send565(5'h11 ^ 5'(i), 6'h2A - 6'(i), 5'h0C + 5'(i),
            links[i] != LINK_P9_I && links[i] != LINK_P9_II);
         send666('{6'h3C ^ 6'(i), 6'h05 + 6'(i), 6'h21 - 6'(i)}, links[i] != LINK_P16_I);
         ticks(6);
         chk_cnt(drop_seen, exp_drop, "dropped pixels");
         check_frame();
      end
      // Unused code refuses data
      setlink(4'h4);
      send565(5'h1F, 6'h00, 5'h1F, 1'b0);
      ticks(6);
      chk_cnt(drop_seen, exp_drop, "unused link");
      // Command in mid pixel discards the first byte
      setlink(LINK_P8_I);
      host_pixel_format <= FMT_16BPP;
      xfer(1'b1, {10'h3FF, 8'h5A});
      send_cmd(8'h2C);
      send565(5'h03, 6'h30, 5'h18, 1'b1);
      check_frame();
      // Stalled memory writes fill the buffer, fifth pixel refused
      setlink(LINK_P16_I);
      fm_write_hold <= 1'b1;
      for (int k = 0; k < 5; k++) send565(5'(k), 6'(3 * k), 5'(k + 7), k < 4);
      ticks(4);
      chk_vec(link_busy, 1'b1, "buffer full");
      chk_cnt(drop_seen, exp_drop, "full drop");
      fm_write_hold <= 1'b0;
      ticks(8);
      chk_vec(link_busy, 1'b0, "buffer drained");
      check_frame();
      // Features and video variant in internal mode
      partial_request <= 1'b1;
      scroll_request <= 1'b1;
      interlace_request <= 1'b1;
      video_port_variant <= 2'h2;
      ticks(4);
      chk_vec({partial_active, scroll_active, interlace_active, rgb_port_active}, 4'hF,
         "features");
      // Sync mode refused while the video path is chosen
      display_sync_mode <= DSM_VSYNC;
      memory_path_select <= 1'b1;
      video_port_variant <= 2'h1;
      ticks(30);
      chk_vec({vsync_mode_active, rgb_port_active}, 2'h0, "path select");
      memory_path_select <= 1'b0;
      ticks(30);
      f0 = frames;
      ticks(30);
      chk_cnt(frames, f0, "idle without pulse");
      chk_vec(vsync_mode_active, 1'b0, "waits for pulse");
      setlink(LINK_P8_II);
      send565(5'h15, 6'h0A, 5'h0E, 1'b1);
      vpulse(20);
      chk_vec({vsync_mode_active, partial_active, scroll_active, interlace_active}, 4'h8,
         "sync mode");
      vpulse(20);
      vpulse(20);
      chk_cnt(frames, f0 + 3, "frame per pulse");
      cmp_mem();
      // Pulse during a running frame is ignored
      vpulse(2);
      vpulse(20);
      chk_cnt(ovr_seen, 1, "overrun");
      chk_cnt(frames, f0 + 4, "overrun frames");
      // Back to internal only at the next pulse
      display_sync_mode <= DSM_INTERNAL;
      ticks(30);
      chk_vec(vsync_mode_active, 1'b1, "held until pulse");
      vpulse(20);
      chk_vec({vsync_mode_active, partial_active}, 2'h1, "internal again");
      check_frame();
      give_verdict();
   end

   // Watchdog against a hang
   initial begin
      ticks(40000);
      fail_count++;
      $display("MISMATCH %0t watchdog expired", $time);
      give_verdict();
   end
endmodule : testbench
